/* verilog/ecc_pkg.sv */
// Purpose: Shared constants for the elliptic-curve engine front end.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package ecc_pkg;
  localparam int WORD_W    = 32;
  localparam int MAX_WORDS = 17;
  localparam int BIG_W     = WORD_W * MAX_WORDS;
  localparam int PTR_N     = 9;
  localparam int IDX_W     = 5;
  localparam int CNT_W     = 10;

  typedef logic [BIG_W:0] big_t;

  localparam logic [11:0] OFS_CTRL0  = 12'h000;
  localparam logic [11:0] OFS_MODDAT = 12'h004;
  localparam logic [11:0] OFS_PTR0   = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h02c;
  localparam logic [11:0] OFS_MASK   = 12'h030;

  // engine_control_zero layout
  localparam int CTL_START   = 0;
  localparam int CTL_OP_LO   = 1;
  localparam int CTL_MANPAR  = 5;
  localparam int CTL_SIZE_LO = 6;
  localparam int CTL_MADR_LO = 8;

  // Status and mask layout
  localparam int ST_DONE = 0;
  localparam int ST_ERR  = 1;
  localparam int ST_BUSY = 2;
  localparam int EV_N    = 2;

  typedef enum logic [1:0] {
    SIZE_NONE = 2'h0,
    SIZE_256  = 2'h1,
    SIZE_384  = 2'h2,
    SIZE_521  = 2'h3
  } ecc_size_e;

  localparam logic [IDX_W-1:0] WORDS_256 = 5'h08;
  localparam logic [IDX_W-1:0] WORDS_384 = 5'h0c;
  localparam logic [IDX_W-1:0] WORDS_521 = 5'h11;

  typedef enum logic [3:0] {
    OP_MOD_MULTIPLY = 4'h0,
    OP_MOD_DIVIDE   = 4'h1,
    OP_MOD_ADD      = 4'h2,
    OP_MOD_SUBTRACT = 4'h3
  } opcode_e;

  localparam int PTR_PX  = 0;
  localparam int PTR_PY  = 1;
  localparam int PTR_PZ  = 2;
  localparam int PTR_QX  = 3;
  localparam int PTR_QY  = 4;
  localparam int PTR_QZ  = 5;
  localparam int PTR_SIG = 6;
  localparam int PTR_RES = 7;
  localparam int PTR_BUF = 8;
endpackage

/* verilog/modular_unit_if.sv */
// Purpose: Carries one modular operation between sequencer and arithmetic unit.
// Assumes: Operands already below the modulus.
// Notes:   done is a one-cycle pulse; result holds until the next start.
interface arith_op_if;
  import ecc_pkg::*;
  logic                 start;
  opcode_e              opcode;
  logic [CNT_W-1:0]     nbits;
  logic [BIG_W-1:0]     a;
  logic [BIG_W-1:0]     b;
  logic [BIG_W-1:0]     m;
  logic [BIG_W-1:0]     result;
  logic                 done;
  modport ctrl (output start, opcode, nbits, a, b, m, input result, done);
  modport unit (input start, opcode, nbits, a, b, m, output result, done);
endinterface

/* verilog/modular_unit.sv */
// Purpose: Big-number modular multiply, divide, add and subtract.
// Assumes: Operands below the modulus; odd modulus for division.
// Notes:   Multiply is one bit per cycle, divide one binary step per cycle.
module modular_unit (
  input  wire logic clk,
  input  wire logic rst_n,
  arith_op_if.unit  io
);
  import ecc_pkg::*;

  typedef enum logic [1:0] {U_IDLE = 2'b00, U_RUN = 2'b01, U_DONE = 2'b11} ustate_e;

  ustate_e          state_reg;
  big_t             r_reg, u_reg, v_reg, x1_reg, x2_reg;
  logic [CNT_W-1:0] cnt_reg;
  big_t             mod_ext, dbl, mstep;

  function automatic big_t addm(big_t a, big_t b, big_t m);
    big_t s;
    s = a + b;
    return (s >= m) ? s - m : s;
  endfunction

  function automatic big_t subm(big_t a, big_t b, big_t m);
    return (a >= b) ? a - b : a + m - b;
  endfunction

  // Halving modulo an odd modulus keeps the value exact
  function automatic big_t halfm(big_t x, big_t m);
    return x[0] ? (x + m) >> 1 : x >> 1;
  endfunction

  assign mod_ext = {1'b0, io.m};
  assign dbl     = addm(r_reg, r_reg, mod_ext);
  assign mstep   = io.a[cnt_reg] ? addm(dbl, {1'b0, io.b}, mod_ext) : dbl;
  assign io.done = (state_reg == U_DONE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= U_IDLE;
      r_reg     <= '0;
      u_reg     <= '0;
      v_reg     <= '0;
      x1_reg    <= '0;
      x2_reg    <= '0;
      cnt_reg   <= '0;
      io.result <= '0;
    end else begin
      unique case (state_reg)
        U_IDLE: if (io.start) begin
          state_reg <= U_RUN;
          r_reg     <= '0;
          u_reg     <= {1'b0, io.b};
          v_reg     <= mod_ext;
          x1_reg    <= {1'b0, io.a};
          x2_reg    <= '0;
          cnt_reg   <= io.nbits - 1'b1;
        end
        U_RUN: unique case (io.opcode)
          OP_MOD_ADD: begin
            io.result <= BIG_W'(addm({1'b0, io.a}, {1'b0, io.b}, mod_ext));
            state_reg <= U_DONE;
          end
          OP_MOD_SUBTRACT: begin
            io.result <= BIG_W'(subm({1'b0, io.a}, {1'b0, io.b}, mod_ext));
            state_reg <= U_DONE;
          end
          OP_MOD_MULTIPLY: begin
            r_reg   <= mstep;
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == '0) begin
              io.result <= mstep[BIG_W-1:0];
              state_reg <= U_DONE;
            end
          end
          default: begin
            // Binary inversion seeded with the dividend yields a/b directly
            if (u_reg == big_t'(1) || u_reg == '0) begin
              io.result <= x1_reg[BIG_W-1:0];
              state_reg <= U_DONE;
            end else if (v_reg == big_t'(1) || v_reg == '0) begin
              io.result <= x2_reg[BIG_W-1:0];
              state_reg <= U_DONE;
            end else if (!u_reg[0]) begin
              u_reg  <= u_reg >> 1;
              x1_reg <= halfm(x1_reg, mod_ext);
            end else if (!v_reg[0]) begin
              v_reg  <= v_reg >> 1;
              x2_reg <= halfm(x2_reg, mod_ext);
            end else if (u_reg >= v_reg) begin
              u_reg  <= u_reg - v_reg;
              x1_reg <= subm(x1_reg, x2_reg, mod_ext);
            end else begin
              v_reg  <= v_reg - u_reg;
              x2_reg <= subm(x2_reg, x1_reg, mod_ext);
            end
          end
        endcase
        U_DONE: state_reg <= U_IDLE;
        default: state_reg <= U_IDLE;
      endcase
    end
  end
endmodule

/* verilog/ecc_engine.sv */
// Purpose: APB-controlled front end of the elliptic-curve engine.
// Assumes: Memory port answers each request with one mem_ack pulse.
// Notes:   Only the four modular operations are carried out here.
//
// What this block does
// - Operands, results and scratch live in memory at programmed pointers.
// - Manual-parameter bit 0 forces the 256-bit width, 1 uses the size field; the modulus is always the loaded one.
// - In manual mode a size field picks 256, 384 or 521 bits.
// - Size field writable only in manual mode, otherwise forced to 256-bit.
// - Software sets start after setup; engine then runs the chosen operation.
// - Operand width is the size setting in manual mode, else 256 bits.
// - Modulus is loaded word by word: index first, then data, LSW at 0.
// - Opcode 0 multiplies P x by P y modulo the modulus.
// - Opcode 1 divides P x by P y modulo a prime, using the buffer.
// - Opcode 2 adds P x and P y modulo the modulus into result.
// - Opcode 3 subtracts P y from P x modulo the modulus into result.
module ecc_engine (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [ecc_pkg::WORD_W-1:0] pwdata,
  output logic      [ecc_pkg::WORD_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           mem_req,
  output logic                           mem_we,
  output logic      [ecc_pkg::WORD_W-1:0] mem_addr,
  output logic      [ecc_pkg::WORD_W-1:0] mem_wdata,
  input  wire logic [ecc_pkg::WORD_W-1:0] mem_rdata,
  input  wire logic                      mem_ack,
  output logic                           irq
);
  import ecc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LOAD_X = 3'b001,
    ST_LOAD_Y = 3'b011,
    ST_CALC   = 3'b010,
    ST_BUF    = 3'b111,
    ST_STORE  = 3'b110
  } state_e;

  arith_op_if op_bus ();

  state_e              state_reg;
  logic [WORD_W-1:0]   ptr_reg [PTR_N];
  logic [WORD_W-1:0]   mod_reg [MAX_WORDS];
  logic [WORD_W-1:0]   mod_data_reg;
  logic [IDX_W-1:0]    mod_idx_reg;
  opcode_e             opcode_reg;
  logic                manual_reg;
  ecc_size_e           size_reg;
  logic [EV_N-1:0]     status_reg;
  logic [EV_N-1:0]     mask_reg;
  logic [IDX_W-1:0]    nwords_reg;
  logic [IDX_W-1:0]    widx_reg;
  opcode_e             run_op_reg;
  logic [BIG_W-1:0]    x_reg, y_reg, m_reg;
  logic                start_reg;
  logic                ready_reg;
  logic [WORD_W-1:0]   rdata_reg;
  logic                slverr_reg;

  logic                access, wr_en, rd_en;
  logic                ctrl_wr, start_req, busy;
  logic                mapped;
  logic [3:0]          ptr_sel;
  logic                ptr_hit;
  logic [EV_N-1:0]     ev_set;
  logic [WORD_W-1:0]   ctrl_view;
  logic [WORD_W-1:0]   rd_mux;
  logic [IDX_W-1:0]    nwords_next;
  logic [WORD_W-1:0]   word_ofs;
  logic                last_word;
  ecc_size_e           size_wr;

  // APB: one wait state so that read data comes from a flop
  assign access  = psel && penable && !ready_reg;
  assign wr_en   = psel && penable && ready_reg && pwrite;
  assign rd_en   = access && !pwrite;
  assign pready  = ready_reg;
  assign prdata  = rdata_reg;
  assign pslverr = slverr_reg;

  assign ptr_sel = 4'((paddr - OFS_PTR0) >> 2);
  assign ptr_hit = (paddr >= OFS_PTR0) && (paddr < OFS_STATUS) && (paddr[1:0] == 2'b00);
  assign mapped  = (paddr == OFS_CTRL0) || (paddr == OFS_MODDAT) || ptr_hit
                || (paddr == OFS_STATUS) || (paddr == OFS_MASK);

  assign busy      = (state_reg != ST_IDLE);
  assign ctrl_wr   = wr_en && mapped && (paddr == OFS_CTRL0);
  assign start_req = ctrl_wr && pwdata[CTL_START] && !busy;
  assign size_wr   = ecc_size_e'(pwdata[CTL_SIZE_LO +: 2]);

  assign ctrl_view = {19'h0, mod_idx_reg, size_reg, manual_reg, opcode_reg, busy};

  always_comb begin
    rd_mux = '0;
    if (paddr == OFS_CTRL0) begin
      rd_mux = ctrl_view;
    end else if (paddr == OFS_MODDAT) begin
      rd_mux = (mod_idx_reg < IDX_W'(MAX_WORDS)) ? mod_reg[mod_idx_reg] : '0;
    end else if (ptr_hit) begin
      rd_mux = ptr_reg[ptr_sel];
    end else if (paddr == OFS_STATUS) begin
      rd_mux = WORD_W'({busy, status_reg});
    end else if (paddr == OFS_MASK) begin
      rd_mux = WORD_W'(mask_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_reg  <= 1'b0;
      rdata_reg  <= '0;
      slverr_reg <= 1'b0;
    end else begin
      ready_reg  <= access;
      slverr_reg <= access && !mapped;
      if (rd_en) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Control register; the size field follows the manual bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opcode_reg  <= OP_MOD_MULTIPLY;
      manual_reg  <= 1'b0;
      size_reg    <= SIZE_256;
      mod_idx_reg <= '0;
    end else if (ctrl_wr) begin
      opcode_reg  <= opcode_e'(pwdata[CTL_OP_LO +: 4]);
      manual_reg  <= pwdata[CTL_MANPAR];
      mod_idx_reg <= pwdata[CTL_MADR_LO +: IDX_W];
      if (!pwdata[CTL_MANPAR]) begin
        size_reg <= SIZE_256;
      end else if (size_wr != SIZE_NONE) begin
        size_reg <= size_wr;
      end
    end
  end

  // Modulus words land at the index written before them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < MAX_WORDS; i++) begin
        mod_reg[i] <= '0;
      end
    end else if (wr_en && paddr == OFS_MODDAT && mod_idx_reg < IDX_W'(MAX_WORDS)) begin
      mod_reg[mod_idx_reg] <= pwdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < PTR_N; i++) begin
        ptr_reg[i] <= '0;
      end
    end else if (wr_en && ptr_hit) begin
      ptr_reg[ptr_sel] <= pwdata;
    end
  end

  // Sticky events: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_reg <= '0;
      mask_reg   <= '0;
    end else begin
      if (wr_en && paddr == OFS_MASK) begin
        mask_reg <= pwdata[EV_N-1:0];
      end
      if (wr_en && paddr == OFS_STATUS) begin
        status_reg <= (status_reg & ~pwdata[EV_N-1:0]) | ev_set;
      end else begin
        status_reg <= status_reg | ev_set;
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

  // Operand width: P256 unless manual parameters choose otherwise
  always_comb begin
    nwords_next = WORDS_256;
    if (manual_reg) begin
      unique case (size_reg)
        SIZE_384: nwords_next = WORDS_384;
        SIZE_521: nwords_next = WORDS_521;
        default:  nwords_next = WORDS_256;
      endcase
    end
  end

  assign word_ofs  = WORD_W'({widx_reg, 2'b00});
  assign last_word = (widx_reg == nwords_reg - 1'b1);

  always_comb begin
    mem_addr = '0;
    unique case (state_reg)
      ST_LOAD_X: mem_addr = ptr_reg[PTR_PX] + word_ofs;
      ST_LOAD_Y: mem_addr = ptr_reg[PTR_PY] + word_ofs;
      ST_BUF:    mem_addr = ptr_reg[PTR_BUF] + word_ofs;
      ST_STORE:  mem_addr = ptr_reg[PTR_RES] + word_ofs;
      default:   mem_addr = '0;
    endcase
  end

  assign mem_we    = (state_reg == ST_BUF) || (state_reg == ST_STORE);
  assign mem_wdata = op_bus.result[widx_reg*WORD_W +: WORD_W];

  assign op_bus.start  = start_reg;
  assign op_bus.opcode = run_op_reg;
  assign op_bus.nbits  = CNT_W'({nwords_reg, 5'h00});
  assign op_bus.a      = x_reg;
  assign op_bus.b      = y_reg;
  assign op_bus.m      = m_reg;

  modular_unit u_modular_unit (
    .clk   (clk),
    .rst_n (rst_n),
    .io    (op_bus)
  );

  // Sequencer: fetch P x, fetch P y, compute, write back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      mem_req    <= 1'b0;
      widx_reg   <= '0;
      nwords_reg <= WORDS_256;
      run_op_reg <= OP_MOD_MULTIPLY;
      x_reg      <= '0;
      y_reg      <= '0;
      m_reg      <= '0;
      start_reg  <= 1'b0;
      ev_set     <= '0;
    end else begin
      start_reg <= 1'b0;
      ev_set    <= '0;
      unique case (state_reg)
        ST_IDLE: if (start_req) begin
          if (pwdata[CTL_OP_LO +: 4] > OP_MOD_SUBTRACT) begin
            ev_set[ST_ERR]  <= 1'b1;
            ev_set[ST_DONE] <= 1'b1;
          end else begin
            state_reg  <= ST_LOAD_X;
            run_op_reg <= opcode_e'(pwdata[CTL_OP_LO +: 4]);
            nwords_reg <= nwords_next;
            widx_reg   <= '0;
            x_reg      <= '0;
            y_reg      <= '0;
            for (int i = 0; i < MAX_WORDS; i++) begin
              m_reg[i*WORD_W +: WORD_W] <= (IDX_W'(i) < nwords_next) ? mod_reg[i] : '0;
            end
            mem_req <= 1'b1;
          end
        end
        ST_LOAD_X, ST_LOAD_Y: if (mem_ack) begin
          if (state_reg == ST_LOAD_X) begin
            x_reg[widx_reg*WORD_W +: WORD_W] <= mem_rdata;
          end else begin
            y_reg[widx_reg*WORD_W +: WORD_W] <= mem_rdata;
          end
          widx_reg <= last_word ? '0 : widx_reg + 1'b1;
          if (last_word && state_reg == ST_LOAD_Y) begin
            mem_req   <= 1'b0;
            state_reg <= ST_CALC;
            start_reg <= 1'b1;
          end else if (last_word) begin
            state_reg <= ST_LOAD_Y;
          end
        end
        ST_CALC: if (op_bus.done) begin
          mem_req   <= 1'b1;
          state_reg <= (run_op_reg == OP_MOD_DIVIDE) ? ST_BUF : ST_STORE;
        end
        ST_BUF: if (mem_ack) begin
          widx_reg <= last_word ? '0 : widx_reg + 1'b1;
          if (last_word) begin
            state_reg <= ST_STORE;
          end
        end
        ST_STORE: if (mem_ack) begin
          widx_reg <= widx_reg + 1'b1;
          if (last_word) begin
            mem_req         <= 1'b0;
            state_reg       <= ST_IDLE;
            ev_set[ST_DONE] <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          mem_req   <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* tb/ecc_engine_checker.sv */
// Purpose: Port assertions for ecc_engine.
// Assumes: Both mask bits stay set while operations run.
// Notes:   Busy is inferred from accepted starts and a rising irq.
module ecc_engine_checker (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [11:0]                paddr,
  input wire logic [ecc_pkg::WORD_W-1:0] pwdata,
  input wire logic [ecc_pkg::WORD_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       mem_req,
  input wire logic                       mem_we,
  input wire logic [ecc_pkg::WORD_W-1:0] mem_addr,
  input wire logic [ecc_pkg::WORD_W-1:0] mem_wdata,
  input wire logic [ecc_pkg::WORD_W-1:0] mem_rdata,
  input wire logic                       mem_ack,
  input wire logic                       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import ecc_pkg::*;
  logic       wr_acc, start_acc, idle_reg;
  logic [1:0] size_reg;
  logic [3:0] op_reg;
  logic [6:0] rd_cnt, wr_cnt, n_words;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign wr_acc    = psel && penable && pready && pwrite && !pslverr;
  assign start_acc = wr_acc && paddr == OFS_CTRL0 && pwdata[CTL_START] && idle_reg;
  assign n_words   = size_reg == 2'h3 ? 7'h11 : size_reg == 2'h2 ? 7'h0c : 7'h08;
  // In manual mode, zero in the size field keeps the old width
  always_ff @(posedge clk) begin
    if (!rst_n) size_reg <= 2'h1;
    else if (wr_acc && paddr == OFS_CTRL0 && !pwdata[CTL_MANPAR]) size_reg <= 2'h1;
    else if (wr_acc && paddr == OFS_CTRL0 && pwdata[CTL_SIZE_LO+:2] != 2'h0)
      size_reg <= pwdata[CTL_SIZE_LO+:2];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) idle_reg <= 1'b1;
    else if (start_acc) idle_reg <= 1'b0;
    else if ($rose(irq)) idle_reg <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) op_reg <= 4'h0;
    else if (start_acc) op_reg <= pwdata[CTL_OP_LO+:4];
  end
  always_ff @(posedge clk) begin
    if (!rst_n || start_acc) begin
      rd_cnt <= 7'h00;
      wr_cnt <= 7'h00;
    end else if (mem_req && mem_ack && mem_we) wr_cnt <= wr_cnt + 7'h01;
    else if (mem_req && mem_ack) rd_cnt <= rd_cnt + 7'h01;
  end
  AST_APB_ONE_WAIT: assert property (
    psel && penable && !pready |=> pready ##1 !pready) else $error("bad wait state");
  AST_SLVERR_MAP: assert property (
    pready |-> pslverr == (paddr > OFS_MASK || paddr[1:0] != 2'h0)) else $error("bad decode");
  AST_START_FETCH: assert property (
    start_acc && pwdata[CTL_OP_LO+:4] <= 4'h3 |-> ##[1:2] mem_req && !mem_we)
    else $error("start did not fetch");
  AST_BAD_OP_QUIET: assert property (
    start_acc && pwdata[CTL_OP_LO+:4] > 4'h3 |=> !mem_req [*4]) else $error("bad op traffic");
  AST_REQ_HOLD: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
      && (!mem_we || $stable(mem_wdata))) else $error("request moved before ack");
  AST_READ_FIRST: assert property (
    mem_req && mem_we |-> rd_cnt == 2 * n_words) else $error("wrong operand word count");
  AST_DONE_WORDS: assert property (
    $rose(irq) && op_reg <= 4'h3 |-> !mem_req
      && wr_cnt == (op_reg == 4'h1 ? 2 * n_words : n_words)) else $error("wrong write count");
  AST_MASK_OFF: assert property (
    wr_acc && paddr == OFS_MASK && pwdata[1:0] == 2'h0 |=> !irq) else $error("masked irq");
  AST_W1C_CLEAR: assert property (
    wr_acc && paddr == OFS_STATUS && pwdata[1:0] == 2'h3 && idle_reg |=> !irq)
    else $error("irq after clear");
endmodule
bind ecc_engine ecc_engine_checker i_chk (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .irq
);

/* tb/mem_model.sv */
// Purpose: System memory behind the engine's memory port.
// Assumes: One held request at a time.
// Notes:   Read data is inverted every cycle outside the ack cycle, so stale data matches only on alternate cycles.
module mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  max_wait,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_reg;
  always @(posedge clk) begin
    if (rst_n && mem_req && mem_ack && mem_we) mem[mem_addr] = mem_wdata;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      wait_reg  <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && wait_reg == 2'h0) begin
      mem_ack   <= 1'b1;
      wait_reg  <= 2'($urandom_range(max_wait));
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule

/* tb/ecc_engine_tb.sv */
// Purpose: Self-checking bench for ecc_engine.
// Assumes: Prime moduli, so every division has an inverse.
// Notes:   Division is checked by multiplying the quotient back.
module ecc_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ecc_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        mem_req, mem_we, mem_ack, irq, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd_q;
  logic [1:0]  max_wait;
  big_t        m_v, a_v, b_v, r_v, e_v;
  int          miscompares, check_count;

  ecc_engine i_dut (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .irq
  );
  mem_model i_mem (
    .clk, .rst_n, .max_wait, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] ptr(int i);
    return 32'h1000 * 32'(i + 1);
  endfunction
  function automatic logic [31:0] c0(int idx, int man, int sz, int op, int st);
    return {19'h0, 5'(idx), 2'(sz), 1'(man), 4'(op), 1'(st)};
  endfunction
  function automatic big_t ref_op(int op, big_t a, big_t b, big_t m);
    logic [2*BIG_W+1:0] p;
    if (op == 0) p = (a * b) % m;
    else if (op == 2) p = (a + b) % m;
    else p = (a + m - b) % m;
    return p[BIG_W:0];
  endfunction

  task automatic report_and_stop();
    $display("miscompares=%0d check_count=%0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  // One idle cycle before each setup keeps psel from being assigned twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      miscompares++;
      report_and_stop();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    if (n == 30000) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  initial begin
    int n;
    int man;
    int sz;
    void'($urandom(32'h7b82));
    {rst_n, psel, penable, pwrite, paddr, pwdata, max_wait} = '0;
    {a_v, b_v, miscompares, check_count} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CTRL0, 32'h0);
    chk(rd_q, 32'h40);
    for (int a = 4; a <= 48; a += 4) begin
      apb(1'b0, 12'(a), 32'h0);
      chk(rd_q, 32'h0);
    end
    apb(1'b1, 12'h100, 32'hffff_ffff);
    chk(32'(err_q), 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd_q, 32'h0);
    apb(1'b1, OFS_CTRL0, c0(0, 0, 3, 0, 0));
    apb(1'b0, OFS_CTRL0, 32'h0);
    chk(rd_q, 32'h40);
    apb(1'b1, OFS_CTRL0, c0(0, 1, 3, 0, 0));
    apb(1'b0, OFS_CTRL0, 32'h0);
    chk(rd_q, 32'he0);
    for (int i = 0; i < 9; i++) apb(1'b1, OFS_PTR0 + 12'(4 * i), ptr(i));
    apb(1'b1, OFS_MASK, 32'h3);
    for (int s = 0; s < 3; s++) begin
      n = s == 0 ? 8 : s == 1 ? 12 : 17;
      man = s == 0 ? 0 : 1;
      sz = s == 0 ? $urandom_range(3) : s + 1;
      max_wait <= 2'(s);
      m_v = (big_t'(1) << (s == 0 ? 255 : s == 1 ? 383 : 521)) - (s == 0 ? 19 : s == 1 ? 187 : 1);
      for (int i = 0; i < n; i++) begin
        apb(1'b1, OFS_CTRL0, c0(i, man, sz, 0, 0));
        apb(1'b1, OFS_MODDAT, m_v[32*i+:32]);
      end
      apb(1'b0, OFS_MODDAT, 32'h0);
      chk(rd_q, m_v[32*(n-1)+:32]);
      for (int op = 0; op < 4; op++) begin
        for (int i = 0; i < 17; i++) begin
          a_v[32*i+:32] = $urandom;
          b_v[32*i+:32] = $urandom;
        end
        a_v = a_v % m_v;
        b_v = b_v % (m_v - 1) + 1;
        for (int i = 0; i < 17; i++) begin
          i_mem.mem[ptr(0) + 32'(4 * i)] = a_v[32*i+:32];
          i_mem.mem[ptr(1) + 32'(4 * i)] = b_v[32*i+:32];
        end
        for (int i = 0; i <= n; i++) i_mem.mem[ptr(7) + 32'(4 * i)] = 32'hdead_0000;
        apb(1'b1, OFS_CTRL0, c0(0, man, sz, op, 1));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd_q, 32'h4);
        if (op == 0) apb(1'b1, OFS_CTRL0, c0(0, man, sz, 2, 1));
        wait_irq();
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd_q, 32'h1);
        if (s == 0 && op == 0) begin
          apb(1'b1, OFS_MASK, 32'h0);
          @(posedge clk);
          chk(32'(irq), 32'h0);
          apb(1'b1, OFS_MASK, 32'h3);
        end
        apb(1'b1, OFS_STATUS, 32'h3);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        r_v = '0;
        for (int i = 0; i < n; i++) r_v[32*i+:32] = i_mem.mem[ptr(7) + 32'(4 * i)];
        if (op == 1) begin
          for (int i = 0; i < n; i++) begin
            chk(i_mem.mem[ptr(8) + 32'(4 * i)], r_v[32*i+:32]);
          end
        end
        e_v = op == 1 ? a_v : ref_op(op, a_v, b_v, m_v);
        if (op == 1) r_v = ref_op(0, r_v, b_v, m_v);
        for (int i = 0; i < 17; i++) chk(r_v[32*i+:32], e_v[32*i+:32]);
        chk(i_mem.mem[ptr(7) + 32'(4 * n)], 32'hdead_0000);
      end
    end
    for (int op = 4; op < 16; op += 11) begin
      apb(1'b1, OFS_CTRL0, c0(0, 1, 0, op, 1));
      wait_irq();
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd_q, 32'h3);
      apb(1'b1, OFS_STATUS, 32'h3);
    end
    report_and_stop();
  end
endmodule
